// [include/deser_pkg.sv]
package deser_pkg;

  // word geometry
  localparam int          WORD_BITS       = 16;
  localparam logic [3:0]  LAST_BIT        = 4'hf;
  localparam logic [3:0]  PCLK_HIGH_FROM  = 4'h8;
  localparam logic [15:0] WORD_RESET      = 16'h0000;
  localparam int          FIFO_DEPTH      = 8;

  // nominal line rates, kbit/s
  localparam int          SERIAL_RATE_KBPS = 2488000;
  localparam int          WORD_RATE_KBPS   = 155520;

  // clock and timing
  localparam int          CLK_PERIOD_PS   = 5000;
  localparam int          LOCK_DELAY_NS   = 800;
  localparam int          LOCK_CYCLES     = (LOCK_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [7:0]  LOCK_COUNT_LAST = 8'(LOCK_CYCLES - 1);
  localparam int          SYNC_MIN_PS     = 1600;
  localparam int          SYNC_MIN_BITS   = 4;

endpackage

// [include/word_stream_if.sv]
`timescale 1ns/1ps
interface word_stream_if #(
  parameter int WIDTH = 16
);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface

// [design/word_fifo.sv]
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic           clk_sys,
  input  wire logic           reset_n,
  word_stream_if.sink         fill,
  word_stream_if.source       drain
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic             full;
  logic             empty;
  logic             do_push;
  logic             do_pop;

  // extra pointer bit tells full from empty
  assign empty       = (wr_ptr == rd_ptr);
  assign full        = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
  assign fill.ready  = !full;
  assign drain.valid = !empty;
  assign drain.data  = mem[rd_ptr[PW-1:0]];
  assign do_push     = fill.valid && !full;
  assign do_pop      = drain.ready && !empty;

  // storage, no reset needed: empty flag guards stale words
  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem[wr_ptr[PW-1:0]] <= fill.data;
    end
  end

  // pointers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // the write pointer may have moved on the edge that made the fifo full, so look one cycle on
  a_fifo_full_block : assert property (@(posedge clk_sys) disable iff (!reset_n)
    full |-> !fill.ready ##1 $stable(wr_ptr))
    else $error("fifo accepted a word while full");

  c_fifo_full : cover property (@(posedge clk_sys) disable iff (!reset_n) full);
endmodule

// [design/serial_deserializer.sv]
`timescale 1ns/1ps
// Operation
// - serial bits are packed into 16-bit words of consecutive received bits; while the fifo is full, incoming bits are lost.
// - words leave at one per parallel clock period, the bit rate divided by sixteen.
// - the bit clock recovered from the incoming stream is the clock that samples every bit.
// - each serial bit is retimed by that clock before it enters the shift path.
// - select low takes the main input, select high the loopback input.
// - a realignment pulse of at least four bit periods drops exactly one bit.
// - a lock status output reports whether clock recovery is locked.
// - word data change on the falling edge of the parallel clock.
// - the one-bit shift completes within two parallel clock cycles of the pulse edge.
// - the bit dropped is the first one of the affected parallel clock cycle.
// - lock status falls at once on loss and rises about 800 ns after lock.
module serial_deserializer
  import deser_pkg::*;
(
  input  wire logic                           clk_sys,
  input  wire logic                           reset_n,
  input  wire logic                           main_serial_in,
  input  wire logic                           loopback_serial_in,
  input  wire logic                           input_select,
  input  wire logic                           realign,
  input  wire logic                           loop_locked,
  input  wire logic                           word_hold,
  output logic                                parallel_clk,
  output logic [deser_pkg::WORD_BITS-1:0]     word_data_out,
  output logic                                word_valid,
  output logic                                lock_lost_n
);
  import deser_pkg::*;

  localparam int SLIP_BOUND = 32;

  logic        main_s1;
  logic        main_s2;
  logic        loop_s1;
  logic        loop_s2;
  logic        sel_s1;
  logic        sel_s2;
  logic        sync_s1;
  logic        sync_s2;
  logic        sync_prev;
  logic        lock_s1;
  logic        lock_s2;
  logic        chosen_bit;
  logic        sync_rise;
  logic        slip_pending;
  logic        slip_now;
  logic        word_end;
  logic        advance;
  logic [3:0]  pclk_count;
  logic [3:0]  next_pclk_count;
  logic [3:0]  bit_count;
  logic [WORD_BITS-1:0] shift;
  logic [7:0]  lock_count;

  word_stream_if #(.WIDTH(WORD_BITS)) fill_if ();
  word_stream_if #(.WIDTH(WORD_BITS)) drain_if ();

  // clk_sys is the recovered bit clock; serial pins pass two flops before any use
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      main_s1 <= 1'b0;
      main_s2 <= 1'b0;
      loop_s1 <= 1'b0;
      loop_s2 <= 1'b0;
    end else begin
      main_s1 <= main_serial_in;
      main_s2 <= main_s1;
      loop_s1 <= loopback_serial_in;
      loop_s2 <= loop_s1;
    end
  end

  // control pins other than word_hold, synchronised the same way; word_hold is used unsynchronised
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sel_s1    <= 1'b0;
      sel_s2    <= 1'b0;
      sync_s1   <= 1'b0;
      sync_s2   <= 1'b0;
      sync_prev <= 1'b0;
      lock_s1   <= 1'b0;
      lock_s2   <= 1'b0;
    end else begin
      sel_s1    <= input_select;
      sel_s2    <= sel_s1;
      sync_s1   <= realign;
      sync_s2   <= sync_s1;
      sync_prev <= sync_s2;
      lock_s1   <= loop_locked;
      lock_s2   <= lock_s1;
    end
  end

  // input choice after retiming, so both paths see equal latency
  assign chosen_bit = sel_s2 ? loop_s2 : main_s2;

  // parallel clock runs free; its falling edge is the 15 -> 0 wrap
  assign next_pclk_count = pclk_count + 4'h1;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pclk_count   <= 4'h0;
      parallel_clk <= 1'b0;
    end else begin
      pclk_count   <= next_pclk_count;
      parallel_clk <= (next_pclk_count >= PCLK_HIGH_FROM);
    end
  end

  // a pulse shorter than the synchroniser window may be missed, hence the 4-bit minimum
  assign sync_rise = sync_s2 && !sync_prev;
  assign slip_now  = slip_pending && (pclk_count == 4'h0);

  // a new edge wins over the clear of the pending request
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      slip_pending <= 1'b0;
    end else if (sync_rise) begin
      slip_pending <= 1'b1;
    end else if (slip_now) begin
      slip_pending <= 1'b0;
    end
  end

  // word assembly; a full fifo stalls the assembler and costs incoming bits
  assign word_end      = (bit_count == LAST_BIT);
  assign fill_if.valid = word_end && !slip_now;
  assign fill_if.data  = {shift[WORD_BITS-2:0], chosen_bit};
  assign advance       = !slip_now && !(word_end && !fill_if.ready);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bit_count <= 4'h0;
      shift     <= WORD_RESET;
    end else if (advance) begin
      bit_count <= bit_count + 4'h1;
      shift     <= {shift[WORD_BITS-2:0], chosen_bit};
    end
  end

  word_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) word_fifo_inst (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .fill    (fill_if.sink),
    .drain   (drain_if.source)
  );

  // output words move only at the parallel clock's falling edge
  assign drain_if.ready = (pclk_count == LAST_BIT) && !word_hold;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      word_data_out <= WORD_RESET;
      word_valid    <= 1'b0;
    end else if (drain_if.ready) begin
      word_valid <= drain_if.valid;
      if (drain_if.valid) begin
        word_data_out <= drain_if.data;
      end
    end
  end

  // lock status: drop at once, rise after the settling delay
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lock_count  <= 8'h00;
      lock_lost_n <= 1'b0;
    end else if (!lock_s2) begin
      lock_count  <= 8'h00;
      lock_lost_n <= 1'b0;
    end else if (lock_count == LOCK_COUNT_LAST) begin
      lock_lost_n <= 1'b1;
    end else begin
      lock_count  <= lock_count + 8'h01;
    end
  end

  a_retime_main_path : assert property (@(posedge clk_sys) disable iff (!reset_n)
    !sel_s2 |-> chosen_bit == $past(main_serial_in, 2))
    else $error("main bit not retimed by two stages");

  a_select_loopback : assert property (@(posedge clk_sys) disable iff (!reset_n)
    sel_s2 |-> chosen_bit == $past(loopback_serial_in, 2))
    else $error("loopback input not chosen while select high");

  a_pclk_divide : assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(parallel_clk) |=> !parallel_clk [*7] ##1 parallel_clk [*8] ##1 !parallel_clk)
    else $error("parallel clock is not bit clock divided by sixteen");

  a_data_on_fall : assert property (@(posedge clk_sys) disable iff (!reset_n)
    $changed(word_data_out) |-> $fell(parallel_clk))
    else $error("word data changed away from parallel clock fall");

  a_slip_drops_bit : assert property (@(posedge clk_sys) disable iff (!reset_n)
    slip_now |=> $stable(bit_count) && $stable(shift) && $past(pclk_count) == 4'h0)
    else $error("realignment did not drop the first bit of the cycle");

  a_slip_in_time : assert property (@(posedge clk_sys) disable iff (!reset_n)
    sync_rise |-> ##[0:SLIP_BOUND] slip_now)
    else $error("realignment not done within two parallel clock cycles");

  a_word_msb_first : assert property (@(posedge clk_sys) disable iff (!reset_n)
    advance && fill_if.valid && fill_if.ready |-> fill_if.data[0] == chosen_bit
      && fill_if.data[1] == shift[0])
    else $error("word bit order wrong");

  a_lock_drop_fast : assert property (@(posedge clk_sys) disable iff (!reset_n)
    !lock_s2 |=> !lock_lost_n)
    else $error("lock status did not fall at once");

  a_lock_rise_delay : assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(lock_lost_n) |-> $past(lock_count) == LOCK_COUNT_LAST && $past(lock_s2))
    else $error("lock status rose before the settling delay");

  a_word_count : assert property (@(posedge clk_sys) disable iff (!reset_n)
    advance && word_end |=> bit_count == 4'h0)
    else $error("word is not sixteen bits");

  c_slip_done   : cover property (@(posedge clk_sys) disable iff (!reset_n) slip_now);
  c_lock_rise   : cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(lock_lost_n));
  c_word_out    : cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(word_valid));
  c_fill_stall  : cover property (@(posedge clk_sys) disable iff (!reset_n)
    fill_if.valid && !fill_if.ready);
endmodule

// [test/word_framer_model.sv]
`timescale 1ns/1ps
module word_framer_model (
  input  wire logic        parallel_clk,
  input  wire logic [15:0] word_data_out,
  input  wire logic        word_valid,
  input  wire logic        stall,
  output logic             word_hold,
  output logic [15:0]      got_word,
  output int               got_count,
  output logic             edge_err
);
  logic [15:0] at_fall;

  initial begin
    at_fall = 16'h0000;
    got_word = 16'h0000;
    got_count = 0;
    edge_err = 1'b0;
  end

  // the bench decides when downstream stalls
  assign word_hold = stall;

  // let the fall's update land before sampling it
  always @(negedge parallel_clk) begin
    #1 at_fall = word_data_out;
  end

  // capture on the rise; a word that moved since the fall launched it early
  always @(posedge parallel_clk) begin
    if (word_data_out !== at_fall) begin
      edge_err = 1'b1;
    end
    if (word_valid === 1'b1) begin
      got_word = word_data_out;
      got_count++;
    end
  end
endmodule

// [test/serial_deserializer_tb.sv]
`timescale 1ns/1ps
module serial_deserializer_tb;
  import deser_pkg::*;
  logic        clk_sys = 0, reset_n = 0, main_serial_in = 0, loopback_serial_in = 0;
  logic        input_select = 0, realign = 0, loop_locked = 0, stall = 0;
  logic        word_hold, parallel_clk, word_valid, lock_lost_n, edge_err;
  logic [15:0] word_data_out, got_word, held;
  logic [15:0] main_pat = 16'h000b, loop_pat = 16'h0035;
  int          bit_idx = 0, got_count, miscompares = 0, check_count = 0, align, c0;

  always #2.5 clk_sys = ~clk_sys;

  // both streams run without pause, earliest bit is the msb of each pattern
  always @(posedge clk_sys) begin
    #1;
    main_serial_in = main_pat[15 - bit_idx];
    loopback_serial_in = loop_pat[15 - bit_idx];
    bit_idx = (bit_idx + 1) % 16;
  end

  serial_deserializer serial_deserializer_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .main_serial_in(main_serial_in),
    .loopback_serial_in(loopback_serial_in), .input_select(input_select),
    .realign(realign), .loop_locked(loop_locked), .word_hold(word_hold),
    .parallel_clk(parallel_clk), .word_data_out(word_data_out),
    .word_valid(word_valid), .lock_lost_n(lock_lost_n));

  word_framer_model word_framer_model_inst (
    .parallel_clk(parallel_clk), .word_data_out(word_data_out),
    .word_valid(word_valid), .stall(stall), .word_hold(word_hold),
    .got_word(got_word), .got_count(got_count), .edge_err(edge_err));

  task automatic check(string what, logic [15:0] exp, logic [15:0] seen);
    check_count++;
    if (exp !== seen) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] rot(logic [15:0] p, int k);
    return (p << (k % 16)) | (p >> (16 - (k % 16)));
  endfunction

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // bounded wait for the framer to take one more word
  task automatic next_word();
    int start;
    start = got_count;
    for (int i = 0; i < 200 && got_count == start; i++) @(posedge clk_sys);
    #1;
  endtask

  // a fresh word must be the pattern at some bit offset
  // a hold leaves a backlog of several words in the fifo, so wait well past it
  task automatic find_align(logic [15:0] pat);
    repeat (10) next_word();
    align = -1;
    for (int k = 0; k < 16; k++) if (got_word === rot(pat, k)) align = k;
    check("word is pattern rotation", 16'h0001, {15'h0000, align >= 0});
  endtask

  task automatic test_lock();
    loop_locked = 1'b1;
    tick(150);
    check("lock early", 16'h0000, {15'h0000, lock_lost_n});
    tick(20);
    check("lock late", 16'h0001, {15'h0000, lock_lost_n});
    loop_locked = 1'b0;
    tick(4);
    check("lock lost", 16'h0000, {15'h0000, lock_lost_n});
  endtask

  task automatic test_main();
    find_align(main_pat);
    next_word();
    check("main word", rot(main_pat, align), got_word);
    c0 = got_count;
    tick(160);
    check("word rate", 16'h000a, 16'(got_count - c0));
    stall = 1'b1;
    held = word_data_out;
    tick(40);
    check("held word", held, word_data_out);
    stall = 1'b0;
    repeat (4) next_word();
    check("after hold", rot(main_pat, align), got_word);
  endtask

  task automatic test_realign();
    realign = 1'b1;
    tick(4);
    realign = 1'b0;
    // words queued before the slip still leave first
    repeat (8) next_word();
    check("slipped word", rot(main_pat, align + 1), got_word);
  endtask

  task automatic test_loopback();
    input_select = 1'b1;
    find_align(loop_pat);
    input_select = 1'b0;
    find_align(main_pat);
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // whole sequence needs about a thousand cycles, so 20000 is ample
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    test_lock();
    test_main();
    test_realign();
    test_loopback();
    check("edge order", 16'h0000, {15'h0000, edge_err});
    finish_test();
  end
endmodule
